// ---- pidpr_defs.svh ----
`ifndef PIDPR_DEFS_SVH
`define PIDPR_DEFS_SVH

// ****************************************
// scaling and arithmetic
// ****************************************
`define PIDPR_SCALE_LIMIT   16'sh7fff
`define PIDPR_GAIN_SHIFT    8
`define PIDPR_SPEED_ZERO    16'sh0000

// ****************************************
// feedback source codes
// ****************************************
`define PIDPR_FB_NONE       3'h0
`define PIDPR_FB_FIRST      3'h1
`define PIDPR_FB_LAST       3'h6
`define PIDPR_FB_COUNT      6

// ****************************************
// predictive source codes
// ****************************************
`define PIDPR_PRED_NONE     4'h0
`define PIDPR_PRED_LAST     4'hb
`define PIDPR_PRED_COUNT    11

// ****************************************
// preset selection codes
// ****************************************
`define PIDPR_PSEL_BASE     2'h0
`define PIDPR_PSEL_TWO      2'h1
`define PIDPR_PSEL_THREE    2'h2
`define PIDPR_PSEL_FOUR     2'h3

// ****************************************
// synchroniser depth
// ****************************************
`define PIDPR_SYNC_STAGES   3

`endif

// ---- pidpr_pkg.sv ----
package pidpr_pkg;

  // ****************************************
  // regulator sequencing
  // ****************************************
  typedef enum logic [1:0] {
    PIDPR_ST_OFF   = 2'b00,
    PIDPR_ST_START = 2'b01,
    PIDPR_ST_RUN   = 2'b10,
    PIDPR_ST_SLEEP = 2'b11
  } pidpr_state_e;

  // ****************************************
  // configuration carriers
  // ****************************************
  typedef struct packed {
    logic signed [15:0] internal_process_ref;
    logic signed [15:0] reference_a;
    logic signed [15:0] preset_ref_two;
    logic signed [15:0] preset_ref_three;
    logic signed [15:0] preset_ref_four;
    logic signed [15:0] manual_reference;
  } pidpr_refs_s;

  typedef struct packed {
    logic signed [15:0] feedback_scale_min;
    logic signed [15:0] feedback_scale_max;
    logic signed [15:0] reference_scale_min;
    logic signed [15:0] reference_scale_max;
  } pidpr_scale_s;

  typedef struct packed {
    logic [15:0] proportional_gain;
    logic [15:0] integral_gain;
    logic [15:0] derivative_gain;
  } pidpr_gains_s;

  typedef struct packed {
    logic [15:0] speed_rise_ramp;
    logic [15:0] speed_fall_ramp;
    logic [15:0] second_rise_ramp;
    logic [15:0] process_ref_ramp;
  } pidpr_ramps_s;

  typedef struct packed {
    logic signed [15:0] error_wake_level;
    logic signed [15:0] feedback_wake_level;
    logic signed [15:0] low_speed_level;
    logic [15:0]        low_speed_time_limit;
  } pidpr_wake_s;

  typedef struct packed {
    logic               fb_alarm_en;
    logic signed [15:0] fb_alarm_low;
    logic signed [15:0] fb_alarm_high;
    logic               err_alarm_en;
    logic [15:0]        err_alarm_level;
  } pidpr_alarm_s;

endpackage

// ---- pidpr_in_sync.sv ----
`timescale 1ns/100ps

// ****************************************
// pin synchroniser with agreement filter
// ****************************************
module pidpr_in_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // pins and filtered levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  genvar b;
  generate
    for (b = 0; b < W; b++)
    begin : g_bit
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_q[b] <= 1'b0;
          s2_q[b] <= 1'b0;
          s3_q[b] <= 1'b0;
        end
        else
        begin
          s1_q[b] <= pin_in[b];
          s2_q[b] <= s1_q[b];
          s3_q[b] <= s2_q[b];
        end
      end

      // a change counts only once stages two and three agree
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          level_q[b] <= 1'b0;
        else if (s2_q[b] == s3_q[b])
          level_q[b] <= s3_q[b];
      end
    end
  endgenerate

endmodule

// ---- pidpr_process_regulator.sv ----
`timescale 1ns/100ps
`include "pidpr_defs.svh"

// Operation
// - preset inputs pick base, two, three, four
// - speed ramps only on predictive changes
// - second rise ramp at start, wake
// - reference ramp only on reference change
// - wake when signed correction exceeds error level
// - reversal flips sign of correction
// - feedback wake threshold, direction by reversal
// - inhibit input clears integral term
// - feedback alarm on logic output
// - error alarm on logic output
// - manual input selects manual reference
// - predictive reference initialises speed at restart
// - regulator enabled only with feedback source
// - eleven predictive reference sources accepted
// - no feedback source keeps regulator off
module pidpr_process_regulator (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rstn,
  // control period and run command, same clock
  input  wire logic                      ctrl_tick,
  input  wire logic                      run_cmd,
  // configuration
  input  wire logic [2:0]                feedback_source_assign,
  input  wire logic [3:0]                predictive_source,
  input  wire logic                      internal_ref_select,
  input  wire logic                      preset_select_en,
  input  wire logic                      manual_auto_en,
  input  wire logic                      correction_reversal,
  input  wire pidpr_pkg::pidpr_refs_s    refs,
  input  wire pidpr_pkg::pidpr_scale_s   scale,
  input  wire pidpr_pkg::pidpr_gains_s   gains,
  input  wire pidpr_pkg::pidpr_ramps_s   ramps,
  input  wire pidpr_pkg::pidpr_wake_s    wake,
  input  wire pidpr_pkg::pidpr_alarm_s   alarm,
  // measured channels
  input  wire logic signed [5:0][15:0]   fb_channels,
  input  wire logic signed [10:0][15:0]  pred_channels,
  // logic input pins
  input  wire logic                      preset_select_low,
  input  wire logic                      preset_select_high,
  input  wire logic                      integral_inhibit,
  input  wire logic                      manual_select,
  // results
  output logic signed [15:0]             speed_ref_q,
  output logic signed [16:0]             process_error_q,
  output logic                           regulator_active,
  output logic                           regulator_asleep,
  output logic                           feedback_alarm_q,
  output logic                           error_alarm_q
);

  // ****************************************
  // reset release and pin capture
  // ****************************************
  logic [1:0] rst_pipe_q;
  logic       rst_n_i;
  logic [3:0] pins_q;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rst_pipe_q <= 2'b00;
    else
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
  end
  assign rst_n_i = rst_pipe_q[1];

  pidpr_in_sync #(.W(4)) u_pins (
    .ref_clk (ref_clk),
    .rst_n   (rst_n_i),
    .pin_in  ({manual_select, integral_inhibit, preset_select_high, preset_select_low}),
    .level_q (pins_q)
  );

  // ****************************************
  // source selection and scaling
  // ****************************************
  pidpr_pkg::pidpr_state_e state_q;
  logic                    enabled;
  logic signed [15:0]      fb_sel;
  logic signed [15:0]      fb_scaled;
  logic signed [15:0]      pred_sel;
  logic signed [15:0]      ref_base;
  logic signed [15:0]      ref_pick;
  logic signed [15:0]      ref_target;
  logic signed [16:0]      err;
  logic signed [17:0]      corr;

  assign enabled = (feedback_source_assign >= `PIDPR_FB_FIRST) &&
                   (feedback_source_assign <= `PIDPR_FB_LAST);
  assign fb_sel  = enabled ? fb_channels[feedback_source_assign - `PIDPR_FB_FIRST] :
                   `PIDPR_SPEED_ZERO;
  assign pred_sel = (predictive_source != `PIDPR_PRED_NONE &&
                     predictive_source <= `PIDPR_PRED_LAST) ?
                    pred_channels[predictive_source - 4'h1] : `PIDPR_SPEED_ZERO;

  function automatic logic signed [15:0] clip(input logic signed [15:0] v,
                                              input logic signed [15:0] lo,
                                              input logic signed [15:0] hi);
    clip = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  assign ref_base = internal_ref_select ? refs.internal_process_ref : refs.reference_a;
  always_comb
  begin
    ref_pick = ref_base;
    if (preset_select_en)
    begin
      case (pins_q[1:0])
        `PIDPR_PSEL_BASE:  ref_pick = ref_base;
        `PIDPR_PSEL_TWO:   ref_pick = refs.preset_ref_two;
        `PIDPR_PSEL_THREE: ref_pick = refs.preset_ref_three;
        `PIDPR_PSEL_FOUR:  ref_pick = refs.preset_ref_four;
        default:           ref_pick = ref_base;
      endcase
    end
  end

  // clip to scale bounds; bounds order is trusted
  assign ref_target = clip((manual_auto_en && pins_q[3]) ? refs.manual_reference : ref_pick,
                           scale.reference_scale_min, scale.reference_scale_max);
  assign fb_scaled  = clip(fb_sel, scale.feedback_scale_min, scale.feedback_scale_max);

  // ****************************************
  // ramps
  // ****************************************
  function automatic logic signed [15:0] ramp_to(input logic signed [15:0] cur,
                                                 input logic signed [15:0] tgt,
                                                 input logic [15:0]        up,
                                                 input logic [15:0]        dn);
    logic signed [17:0] nxt;
    nxt = 18'(tgt);
    if (tgt > cur && up != 16'h0000)
    begin
      nxt = 18'(cur) + $signed({2'b00, up});
      if (nxt > 18'(tgt))
        nxt = 18'(tgt);
    end
    else if (tgt < cur && dn != 16'h0000)
    begin
      nxt = 18'(cur) - $signed({2'b00, dn});
      if (nxt < 18'(tgt))
        nxt = 18'(tgt);
    end
    ramp_to = nxt[15:0];
  endfunction

  logic signed [15:0] ref_ramp_q;
  logic signed [15:0] pred_ramp_q;

  always_ff @(posedge ref_clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ref_ramp_q <= `PIDPR_SPEED_ZERO;
    else if (state_q == pidpr_pkg::PIDPR_ST_OFF)
      ref_ramp_q <= ref_target;
    else if (ctrl_tick)
      ref_ramp_q <= ramp_to(ref_ramp_q, ref_target, ramps.process_ref_ramp,
                            ramps.process_ref_ramp);
  end

  // predictive loaded at start, ramped after
  always_ff @(posedge ref_clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pred_ramp_q <= `PIDPR_SPEED_ZERO;
    else if (state_q == pidpr_pkg::PIDPR_ST_OFF)
      pred_ramp_q <= pred_sel;
    else if (ctrl_tick)
      pred_ramp_q <= ramp_to(pred_ramp_q, pred_sel, ramps.speed_rise_ramp,
                             ramps.speed_fall_ramp);
  end

  // ****************************************
  // three-term regulator
  // ****************************************
  logic signed [17:0] corr_prev_q;
  logic signed [39:0] integ_q;
  logic signed [34:0] p_term;
  logic signed [34:0] i_term;
  logic signed [35:0] d_term;
  logic signed [40:0] pid_sum;
  logic signed [40:0] pid_shift;
  logic signed [15:0] pid_out;
  logic signed [17:0] spd_sum;
  logic signed [15:0] speed_tgt;
  logic               regulating;

  assign err = 17'(ref_ramp_q) - 17'(fb_scaled);
  // reversal turns a positive error into slowing
  assign corr = correction_reversal ? -18'(err) : 18'(err);
  assign regulating = (state_q == pidpr_pkg::PIDPR_ST_START) ||
                      (state_q == pidpr_pkg::PIDPR_ST_RUN);

  assign p_term = $signed({1'b0, gains.proportional_gain}) * corr;
  assign i_term = $signed({1'b0, gains.integral_gain}) * corr;
  assign d_term = $signed({1'b0, gains.derivative_gain}) * (19'(corr) - 19'(corr_prev_q));
  assign pid_sum   = 41'(p_term) + 41'(integ_q) + 41'(d_term);
  assign pid_shift = pid_sum >>> `PIDPR_GAIN_SHIFT;
  assign pid_out   = (pid_shift < 0) ? `PIDPR_SPEED_ZERO :
                     ((pid_shift > 41'(`PIDPR_SCALE_LIMIT)) ? `PIDPR_SCALE_LIMIT :
                      pid_shift[15:0]);
  assign spd_sum   = 18'(pred_ramp_q) + 18'(pid_out);
  assign speed_tgt = (spd_sum < 0) ? `PIDPR_SPEED_ZERO :
                     ((spd_sum > 18'(`PIDPR_SCALE_LIMIT)) ? `PIDPR_SCALE_LIMIT :
                      spd_sum[15:0]);

  always_ff @(posedge ref_clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
      integ_q <= 40'sh0;
    else if (pins_q[2] || !regulating)
      integ_q <= 40'sh0;
    else if (ctrl_tick)
      integ_q <= integ_q + 40'(i_term);
  end

  always_ff @(posedge ref_clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
      corr_prev_q <= 18'sh0;
    else if (!regulating)
      corr_prev_q <= corr;
    else if (ctrl_tick)
      corr_prev_q <= corr;
  end

  // ****************************************
  // sequencing, sleep and wake
  // ****************************************
  logic [15:0] slow_cnt_q;
  logic        err_wake;
  logic        fb_wake;
  logic        go;

  assign go = run_cmd && enabled;
  assign err_wake = corr > 18'(wake.error_wake_level);
  assign fb_wake  = correction_reversal ? (fb_scaled < wake.feedback_wake_level) :
                                          (fb_scaled > wake.feedback_wake_level);

  always_ff @(posedge ref_clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q     <= pidpr_pkg::PIDPR_ST_OFF;
      speed_ref_q <= `PIDPR_SPEED_ZERO;
      slow_cnt_q  <= 16'h0000;
    end
    // no source or no run keeps it off
    else if (!go)
    begin
      state_q     <= pidpr_pkg::PIDPR_ST_OFF;
      speed_ref_q <= `PIDPR_SPEED_ZERO;
      slow_cnt_q  <= 16'h0000;
    end
    else
    begin
      case (state_q)
        pidpr_pkg::PIDPR_ST_OFF:
        begin
          state_q     <= pidpr_pkg::PIDPR_ST_START;
          speed_ref_q <= pred_sel;
        end
        pidpr_pkg::PIDPR_ST_START:
        begin
          // second rise ramp toward regulator output
          if (ctrl_tick)
          begin
            speed_ref_q <= ramp_to(speed_ref_q, speed_tgt, ramps.second_rise_ramp,
                                   16'h0000);
            if (ramp_to(speed_ref_q, speed_tgt, ramps.second_rise_ramp, 16'h0000) ==
                speed_tgt)
              state_q <= pidpr_pkg::PIDPR_ST_RUN;
          end
        end
        pidpr_pkg::PIDPR_ST_RUN:
        begin
          if (ctrl_tick)
          begin
            speed_ref_q <= speed_tgt;
            // zero limit disables the sleep timer
            if (speed_tgt >= wake.low_speed_level || wake.low_speed_time_limit == 16'h0000)
              slow_cnt_q <= 16'h0000;
            else if (slow_cnt_q + 16'h0001 >= wake.low_speed_time_limit)
            begin
              state_q     <= pidpr_pkg::PIDPR_ST_SLEEP;
              speed_ref_q <= `PIDPR_SPEED_ZERO;
              slow_cnt_q  <= 16'h0000;
            end
            else
              slow_cnt_q <= slow_cnt_q + 16'h0001;
          end
        end
        pidpr_pkg::PIDPR_ST_SLEEP:
        begin
          // wake through the second rise ramp
          if (err_wake || fb_wake)
            state_q <= pidpr_pkg::PIDPR_ST_START;
        end
        default:
          state_q <= pidpr_pkg::PIDPR_ST_OFF;
      endcase
    end
  end

  // ****************************************
  // alarms and status
  // ****************************************
  logic fb_alarm_c;
  logic err_alarm_c;

  assign fb_alarm_c  = enabled && alarm.fb_alarm_en &&
                       (fb_scaled < alarm.fb_alarm_low || fb_scaled > alarm.fb_alarm_high);
  assign err_alarm_c = enabled && alarm.err_alarm_en &&
                       ((err < 0 ? -err : err) > 17'($signed({1'b0, alarm.err_alarm_level})));

  always_ff @(posedge ref_clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      feedback_alarm_q <= 1'b0;
      error_alarm_q    <= 1'b0;
      process_error_q  <= 17'sh0;
    end
    else
    begin
      feedback_alarm_q <= fb_alarm_c;
      error_alarm_q    <= err_alarm_c;
      process_error_q  <= enabled ? err : 17'sh0;
    end
  end

  assign regulator_active = regulating;
  assign regulator_asleep = (state_q == pidpr_pkg::PIDPR_ST_SLEEP);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_i);

  sequence s_asleep_wake;
    state_q == pidpr_pkg::PIDPR_ST_SLEEP ##0 go ##0 (err_wake || fb_wake);
  endsequence

  a_preset_pick_two: assert property (
    preset_select_en && !(manual_auto_en && pins_q[3]) && pins_q[1:0] == 2'b01 |->
    ref_target == clip(refs.preset_ref_two, scale.reference_scale_min,
                       scale.reference_scale_max))
    else $error("preset two not selected");
  a_start_from_pred: assert property (
    state_q == pidpr_pkg::PIDPR_ST_OFF && go |=>
    speed_ref_q == $past(pred_sel) && pred_ramp_q == $past(pred_sel))
    else $error("start speed not predictive");
  a_start_rise_step: assert property (
    state_q == pidpr_pkg::PIDPR_ST_START && go && ctrl_tick &&
    ramps.second_rise_ramp != 16'h0000 |=>
    18'(speed_ref_q) - 18'($past(speed_ref_q)) <=
    $signed({2'b00, $past(ramps.second_rise_ramp)}))
    else $error("start ramp step too large");
  a_ref_ramp_step: assert property (
    state_q != pidpr_pkg::PIDPR_ST_OFF && ctrl_tick && ramps.process_ref_ramp != 16'h0000 &&
    ref_target > ref_ramp_q |=> 18'(ref_ramp_q) - 18'($past(ref_ramp_q)) <=
    18'($past(ramps.process_ref_ramp)))
    else $error("reference ramp step too large");
  a_wake_to_start: assert property (
    s_asleep_wake |=> state_q == pidpr_pkg::PIDPR_ST_START ##1
    state_q != pidpr_pkg::PIDPR_ST_SLEEP)
    else $error("sleep did not wake");
  a_fb_wake_dir: assert property (
    state_q == pidpr_pkg::PIDPR_ST_SLEEP && go && correction_reversal &&
    fb_scaled < wake.feedback_wake_level |=> state_q == pidpr_pkg::PIDPR_ST_START)
    else $error("reversed feedback wake missed");
  a_integ_shorted: assert property (
    pins_q[2] [*2] |-> integ_q == 40'sh0)
    else $error("integral not shorted");
  a_fb_alarm_out: assert property (
    fb_alarm_c |=> feedback_alarm_q)
    else $error("feedback alarm missing");
  a_err_alarm_out: assert property (
    !err_alarm_c |=> !error_alarm_q)
    else $error("error alarm spurious");
  a_no_source_off: assert property (
    !enabled |=> state_q == pidpr_pkg::PIDPR_ST_OFF && speed_ref_q == `PIDPR_SPEED_ZERO)
    else $error("regulator active without source");

endmodule

// ---- pidpr_plant_model.sv ----
`timescale 1ns/100ps

// ****************************************
// sensors and predictive sources
// ****************************************
module pidpr_plant_model (
  // level of the process sensor
  input  wire logic signed [15:0]  fb_level,
  // measured channels
  output logic signed [5:0][15:0]  fb_channels,
  output logic signed [10:0][15:0] pred_channels
);
  // all six feedback inputs see one sensor, so source codes 1 to 6 all read it
  always_comb
  begin
    for (int i = 0; i < 6; i++)
      fb_channels[i] = fb_level;
  end

  // predictive sources carry distinct values to expose a wrong pick
  always_comb
  begin
    for (int k = 0; k < 11; k++)
      pred_channels[k] = 16'(100 * (k + 1));
  end
endmodule

// ---- test_pidpr_process_regulator.sv ----
`timescale 1ns/100ps

module test_pidpr_process_regulator;
  // ****************************************
  // stimulus and results
  // ****************************************
  logic ref_clk, rstn, ctrl_tick, run_cmd, internal_ref_select, preset_select_en;
  logic manual_auto_en, correction_reversal, preset_select_low, preset_select_high;
  logic integral_inhibit, manual_select, regulator_active, regulator_asleep;
  logic feedback_alarm_q, error_alarm_q;
  logic [2:0] feedback_source_assign;
  logic [3:0] predictive_source;
  pidpr_pkg::pidpr_refs_s  refs;
  pidpr_pkg::pidpr_scale_s scale;
  pidpr_pkg::pidpr_gains_s gains;
  pidpr_pkg::pidpr_ramps_s ramps;
  pidpr_pkg::pidpr_wake_s  wake;
  pidpr_pkg::pidpr_alarm_s alarm;
  logic signed [5:0][15:0]  fb_channels;
  logic signed [10:0][15:0] pred_channels;
  logic signed [15:0]       fb_level, speed_ref_q;
  logic signed [16:0]       process_error_q;
  int                       num_errors, cmp_count;

  pidpr_plant_model i_pidpr_plant_model (.fb_level, .fb_channels, .pred_channels);

  pidpr_process_regulator i_pidpr_process_regulator (.ref_clk, .rstn, .ctrl_tick,
    .run_cmd, .feedback_source_assign, .predictive_source, .internal_ref_select,
    .preset_select_en, .manual_auto_en, .correction_reversal, .refs, .scale, .gains,
    .ramps, .wake, .alarm, .fb_channels, .pred_channels, .preset_select_low,
    .preset_select_high, .integral_inhibit, .manual_select, .speed_ref_q,
    .process_error_q, .regulator_active, .regulator_asleep, .feedback_alarm_q,
    .error_alarm_q);

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // scales kept inside the limit, reference range inside sensor range, no d gain
  task automatic cfg();
    refs = '{16'sd1000, 16'sd2000, 16'sd3000, 16'sd4000, 16'sd5000, 16'sd7000};
    scale = '{16'sd0, 16'sh7fff, 16'sd0, 16'sh7fff};
    gains = '{16'h0100, 16'h0000, 16'h0000};
    ramps = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    wake = '{16'sh7fff, 16'sh7fff, 16'sd0, 16'h0000};
    alarm = '{1'b0, 16'sd0, 16'sd0, 1'b0, 16'h0000};
    {internal_ref_select, preset_select_en, manual_auto_en, correction_reversal} = 4'hc;
    {preset_select_low, preset_select_high, integral_inhibit, manual_select} = 4'h0;
    feedback_source_assign = 3'h1;
    predictive_source = 4'h0;
    fb_level = 16'sd0;
  endtask

  task automatic ticks(input int n);
    repeat (n)
    begin
      ctrl_tick = 1'b1;
      @(negedge ref_clk);
    end
    ctrl_tick = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic restart();
    run_cmd = 1'b0;
    repeat (2) @(negedge ref_clk);
    run_cmd = 1'b1;
    @(negedge ref_clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_nosrc();
    for (int s = 0; s < 8; s += 7)
    begin
      feedback_source_assign = 3'(s);
      run_cmd = 1'b1;
      ticks(3);
      chk(regulator_active, 17'h0);
      chk(17'(speed_ref_q), 17'h0);
      chk(process_error_q, 17'h0);
    end
    feedback_source_assign = 3'h1;
    $display("test nosrc done");
  endtask

  // start jumps to the predictive value, the speed ramp is not applied
  task automatic t_pred();
    ramps.speed_rise_ramp = 16'h000a;
    for (int k = 1; k < 12; k++)
    begin
      predictive_source = 4'(k);
      restart();
      chk(17'(speed_ref_q), 17'(100 * k));
      chk(regulator_active, 17'h1);
    end
    predictive_source = 4'h0;
    ramps.speed_rise_ramp = 16'h0000;
    $display("test pred done");
  endtask

  task automatic t_preset();
    restart();
    for (int i = 0; i < 4; i++)
    begin
      {preset_select_high, preset_select_low} = 2'(i);
      ticks(8);
      chk(process_error_q, 17'(i == 0 ? 1000 : 2000 + 1000 * i));
    end
    preset_select_en = 1'b0;
    ticks(8);
    chk(process_error_q, 17'd1000);
    internal_ref_select = 1'b0;
    ticks(8);
    chk(process_error_q, 17'd2000);
    {internal_ref_select, preset_select_high, preset_select_low} = 3'h4;
    $display("test preset done");
  endtask

  // second ramp limits the climb after start, then p term alone sets speed
  task automatic t_rev();
    ramps.second_rise_ramp = 16'd100;
    restart();
    ticks(3);
    chk(speed_ref_q > 0 && speed_ref_q <= 300, 17'h1);
    ticks(12);
    chk(17'(speed_ref_q), 17'd1000);
    correction_reversal = 1'b1;
    ticks(4);
    chk(17'(speed_ref_q), 17'h0);
    chk(process_error_q, 17'd1000);
    correction_reversal = 1'b0;
    ramps.second_rise_ramp = 16'h0;
    $display("test rev done");
  endtask

  task automatic t_integ();
    gains = '{16'h0000, 16'h0100, 16'h0000};
    integral_inhibit = 1'b1;
    // let the pin filter settle so no tick integrates before the inhibit
    repeat (4) @(negedge ref_clk);
    restart();
    ticks(8);
    chk(17'(speed_ref_q), 17'h0);
    integral_inhibit = 1'b0;
    ticks(8);
    chk(speed_ref_q > 0, 17'h1);
    gains = '{16'h0100, 16'h0000, 16'h0000};
    $display("test integ done");
  endtask

  task automatic t_alarm();
    alarm = '{1'b1, 16'sd100, 16'sd2000, 1'b1, 16'd100};
    fb_level = 16'sd3000;
    ticks(2);
    chk(feedback_alarm_q, 17'h1);
    fb_level = 16'sd500;
    ticks(2);
    chk(feedback_alarm_q, 17'h0);
    chk(error_alarm_q, 17'h1);
    fb_level = 16'sd950;
    ticks(2);
    chk(error_alarm_q, 17'h0);
    alarm.fb_alarm_en = 1'b0;
    alarm.err_alarm_en = 1'b0;
    fb_level = 16'sd0;
    $display("test alarm done");
  endtask

  task automatic t_manual();
    ramps.process_ref_ramp = 16'd1000;
    {manual_auto_en, manual_select} = 2'h3;
    ticks(8);
    chk(process_error_q, 17'd5000);
    ticks(8);
    chk(process_error_q, 17'd7000);
    ramps.process_ref_ramp = 16'h0000;
    manual_select = 1'b0;
    ticks(8);
    chk(process_error_q, 17'd1000);
    manual_auto_en = 1'b0;
    $display("test manual done");
  endtask

  // low speed sleep, then wake by feedback, by error, and by reversed feedback
  task automatic t_sleep();
    wake = '{16'sh7fff, 16'sd5000, 16'sd2000, 16'd3};
    restart();
    ticks(8);
    chk({regulator_asleep, speed_ref_q}, 17'h1_0000);
    fb_level = 16'sd6000;
    repeat (2) @(negedge ref_clk);
    chk({regulator_asleep, regulator_active}, 17'h1);
    fb_level = 16'sd0;
    ticks(10);
    chk(regulator_asleep, 17'h1);
    wake.error_wake_level = 16'sd500;
    repeat (2) @(negedge ref_clk);
    chk({regulator_asleep, regulator_active}, 17'h1);
    wake = '{16'sh7fff, -16'sd100, 16'sd2000, 16'd3};
    correction_reversal = 1'b1;
    ticks(10);
    chk(regulator_asleep, 17'h1);
    wake.feedback_wake_level = 16'sd500;
    repeat (2) @(negedge ref_clk);
    chk({regulator_asleep, regulator_active}, 17'h1);
    $display("test sleep done");
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************
  // sequence and watchdog
  // ****************************************
  initial
  begin
    {rstn, ctrl_tick, run_cmd} = 3'h0;
    cfg();
    repeat (2) @(negedge ref_clk);
    chk({regulator_active, speed_ref_q}, 17'h0);
    rstn = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_nosrc();
    t_pred();
    t_preset();
    t_rev();
    t_integ();
    t_alarm();
    t_manual();
    t_sleep();
    results();
  end

  // whole sequence needs under 2000 cycles
  initial
  begin
    #800000;
    num_errors++;
    results();
  end
endmodule
